// *** include/i2cmd_params.svh ***
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB, each register one aligned word at byte address 4 x index
// Notes:   Definitions only
`ifndef I2CMD_PARAMS_SVH
`define I2CMD_PARAMS_SVH

// ==========================================================
// Register indexes
`define I2CMD_IDX_EN 16'h4340
`define I2CMD_IDX_CTL 16'h4342
`define I2CMD_IDX_DAT 16'h4344
`define I2CMD_IDX_ICTL 16'h4346
`define I2CMD_IDX_ISTS 16'h4348

// ==========================================================
// Field positions
`define I2CMD_EN_BIT 0
`define I2CMD_CTL_START 0
`define I2CMD_CTL_STOP 1
`define I2CMD_CTL_TXBUSY 8
`define I2CMD_CTL_RXBUSY 9
`define I2CMD_DAT_ACK 8
`define I2CMD_DAT_TXGO 9
`define I2CMD_DAT_RXGO 10
`define I2CMD_DAT_RXFULL 11
`define I2CMD_IRQ_TX 0
`define I2CMD_IRQ_RX 1

// ==========================================================
// Reset values
`define I2CMD_BYTE_RST 8'h00
`define I2CMD_IRQ_RST 2'h0

// ==========================================================
// Timing: quarter of an SCL period at 100 kbit/s
`define I2CMD_CLK_NS 20
`define I2CMD_QTR_NS 2500
`define I2CMD_QTR_CYC ((`I2CMD_QTR_NS + `I2CMD_CLK_NS - 1) / `I2CMD_CLK_NS)

`endif

// *** include/i2cmd_pkg.sv ***
// Purpose: Types and shared decode for the I2C master data path
// Assumes: Nothing beyond the parameter header
// Notes:   States are listed without codes
package i2cmd_pkg;

    // ==========================================================
    // Engine states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_ACK,
        ST_STOP
    } i2cmd_state_t;

    // ==========================================================
    // Word address match
    function automatic logic i2cmd_hit(input logic [31:0] addr, input logic [15:0] idx);
        return addr == {14'h0000, idx, 2'b00};
    endfunction

endpackage

// *** logic/i2cmd_sync.sv ***
// Purpose: Two-flop synchroniser for the bus line inputs
// Assumes: Lines idle high
// Notes:   First stage feeds only the second
`timescale 1ns/1ns
module i2cmd_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_s,
    output logic sda_s
);
    logic [1:0] meta;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 2'h3;
            scl_s <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            meta <= {scl_i, sda_i};
            scl_s <= meta[1];
            sda_s <= meta[0];
        end
    end
endmodule

// *** logic/i2cmd_tick.sv ***
// Purpose: Quarter-bit enable pulse for the bus engine
// Assumes: pclk at 50 MHz
// Notes:   Counter held at zero while not running
`timescale 1ns/1ns
`include "i2cmd_params.svh"
module i2cmd_tick (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    output logic tick
);
    localparam logic [7:0] LAST = 8'(`I2CMD_QTR_CYC - 1);
    logic [7:0] cnt;
    wire wrap = (cnt == LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 8'h00;
            tick <= 1'b0;
        end else begin
            cnt <= (!run || wrap) ? 8'h00 : cnt + 8'h01;
            tick <= run & wrap;
        end
    end
endmodule

// *** logic/i2cmd_top.sv ***
// Purpose: I2C master byte engine, data register and interrupt logic behind APB
// Assumes: Open-drain lines with external pull-ups; one 50 MHz clock
// Notes:   Zero-wait APB with read data captured in the setup cycle
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
`include "i2cmd_params.svh"

// Function
// - Software loads the byte and sets transmit_go; may re-arm during a transfer.
// - transmit_go clears when the byte moves into the shift register.
// - After sending, ack_bit records the slave reply: 0 ack, 1 none.
// - When receiving, ack_bit is driven as the reply bit.
// - A new transmit byte starts only after the current transfer ends.
// - Transmit bits go out MSB first, 0 as low.
// - Transmit-empty cause is raised when the byte enters the shift register.
// - receive_go starts a reception once the current byte has finished.
// - Completed byte copies to xfer_byte, sets rx_full_flag and receive cause.
// - A later byte overwrites an unread xfer_byte silently.
// - Received bits arrive MSB first, high stored as 1.
// - Interrupt control bit 1 gates the receive-full request; reset 0.
// - Interrupt control bit 0 gates the transmit-empty request; reset 0.
// - xfer_byte, ack_bit and enables reset to 0.
// - Both causes share one interrupt output.
// - Reading the data register clears rx_full_flag.
// - receive_go clears once bit D7 is loaded into the shift register.
module i2cmd_top
    import i2cmd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe,
    output logic sda_o,
    output logic sda_oe
);
    // ==========================================================
    // Register state
    logic enable;
    logic start_req;
    logic stop_req;
    logic [7:0] xfer_byte;
    logic ack_bit;
    logic transmit_go;
    logic receive_go;
    logic rx_full_flag;
    logic [1:0] irq_ctrl;
    logic [1:0] irq_status;
    logic rx_done_d;

    // ==========================================================
    // Engine state
    i2cmd_state_t state;
    logic [1:0] phase;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    logic dir_rx;
    logic bus_busy;
    logic tick;
    logic scl_s;
    logic sda_s;

    // ==========================================================
    // APB decode
    wire hit_en = i2cmd_hit(paddr, `I2CMD_IDX_EN);
    wire hit_ctl = i2cmd_hit(paddr, `I2CMD_IDX_CTL);
    wire hit_dat = i2cmd_hit(paddr, `I2CMD_IDX_DAT);
    wire hit_ictl = i2cmd_hit(paddr, `I2CMD_IDX_ICTL);
    wire hit_ists = i2cmd_hit(paddr, `I2CMD_IDX_ISTS);
    wire mapped = hit_en | hit_ctl | hit_dat | hit_ictl | hit_ists;
    wire access = psel & penable;
    wire setup_rd = psel & ~penable & ~pwrite;
    wire wr = access & pwrite & mapped;
    wire wr_en = wr & hit_en;
    wire wr_ctl = wr & hit_ctl;
    wire wr_dat = wr & hit_dat;
    wire wr_ictl = wr & hit_ictl;
    wire wr_ists = wr & hit_ists;
    wire rd_dat = access & ~pwrite & hit_dat;

    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // ==========================================================
    // Engine events
    wire tx_busy = (state == ST_DATA || state == ST_ACK) && !dir_rx;
    wire rx_busy = (state == ST_DATA || state == ST_ACK) && dir_rx;
    wire in_idle = (state == ST_IDLE) && enable;
    wire go_start = in_idle && tick && start_req;
    wire tx_load = in_idle && tick && !start_req && bus_busy && transmit_go;
    wire rx_begin = in_idle && tick && !start_req && bus_busy && !transmit_go && receive_go;
    wire go_stop = in_idle && tick && !start_req && bus_busy && !transmit_go && !receive_go
        && stop_req;
    // Hold the high phase while a slave stretches the clock
    wire stall = (phase == 2'd2) && !scl_s && !scl_oe;
    wire step = tick && !stall && (state != ST_IDLE);
    wire q0 = step && (phase == 2'd0);
    wire q2 = step && (phase == 2'd2);
    wire q3 = step && (phase == 2'd3);
    wire d7_load = q2 && (state == ST_DATA) && dir_rx && (bitcnt == 3'd0);
    wire rx_done = q3 && (state == ST_DATA) && dir_rx && (bitcnt == 3'd7);
    wire ack_sample = q2 && (state == ST_ACK) && !dir_rx;
    wire start_done = q3 && (state == ST_START);
    wire stop_done = q3 && (state == ST_STOP);
    // A byte landing around a read keeps its flag set
    wire rd_clr = rd_dat && !rx_done && !rx_done_d;
    wire [1:0] irq_events = {rx_done, tx_load};

    // ==========================================================
    // Read mux
    wire [31:0] rd_en = {31'h00000000, enable};
    wire [31:0] rd_ctl = {22'h000000, rx_busy, tx_busy, 6'h00, stop_req, start_req};
    wire [31:0] rd_dat_w = {20'h00000, rx_full_flag, receive_go, transmit_go, ack_bit,
        xfer_byte};
    wire [31:0] rd_ictl = {30'h00000000, irq_ctrl};
    wire [31:0] rd_ists = {30'h00000000, irq_status};
    wire [31:0] rd_mux = hit_en ? rd_en :
        hit_ctl ? rd_ctl :
        hit_dat ? rd_dat_w :
        hit_ictl ? rd_ictl :
        hit_ists ? rd_ists : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_rd) begin
            prdata <= rd_mux;
        end
    end

    // ==========================================================
    // Line synchroniser and quarter-bit timer
    i2cmd_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .scl_s(scl_s),
        .sda_s(sda_s)
    );

    i2cmd_tick u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .run(enable),
        .tick(tick)
    );

    // ==========================================================
    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable <= 1'b0;
            start_req <= 1'b0;
            stop_req <= 1'b0;
            irq_ctrl <= `I2CMD_IRQ_RST;
        end else begin
            if (wr_en) begin
                enable <= pwdata[`I2CMD_EN_BIT];
            end
            if (start_done) begin
                start_req <= 1'b0;
            end
            if (stop_done) begin
                stop_req <= 1'b0;
            end
            if (wr_ctl) begin
                start_req <= pwdata[`I2CMD_CTL_START];
                stop_req <= pwdata[`I2CMD_CTL_STOP];
            end
            if (wr_ictl) begin
                irq_ctrl <= pwdata[1:0];
            end
        end
    end

    // ==========================================================
    // Data register and handshake bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_byte <= `I2CMD_BYTE_RST;
            ack_bit <= 1'b0;
            transmit_go <= 1'b0;
            receive_go <= 1'b0;
        end else begin
            if (tx_load) begin
                transmit_go <= 1'b0;
            end
            if (d7_load) begin
                receive_go <= 1'b0;
            end
            // A software re-arm in the same cycle stands as a new request
            if (wr_dat) begin
                xfer_byte <= pwdata[7:0];
                ack_bit <= pwdata[`I2CMD_DAT_ACK];
                transmit_go <= pwdata[`I2CMD_DAT_TXGO];
                receive_go <= pwdata[`I2CMD_DAT_RXGO];
            end
            if (rx_done) begin
                xfer_byte <= shreg;
            end
            if (ack_sample) begin
                ack_bit <= sda_s;
            end
        end
    end

    // ==========================================================
    // Receive flag and interrupt status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_full_flag <= 1'b0;
            rx_done_d <= 1'b0;
            irq_status <= `I2CMD_IRQ_RST;
        end else begin
            rx_done_d <= rx_done;
            if (rx_done) begin
                rx_full_flag <= 1'b1;
            end else if (rd_clr) begin
                rx_full_flag <= 1'b0;
            end
            // Set wins over a write-one clear
            irq_status <= (irq_status & ~(wr_ists ? pwdata[1:0] : 2'b00)) | irq_events;
        end
    end

    // Single level request
    assign irq = |(irq_status & irq_ctrl);

    // ==========================================================
    // Byte engine: four quarter-bit steps per bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            phase <= 2'd0;
            bitcnt <= 3'd0;
            shreg <= 8'h00;
            dir_rx <= 1'b0;
            bus_busy <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else if (!enable) begin
            state <= ST_IDLE;
            phase <= 2'd0;
            bus_busy <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else if (state == ST_IDLE) begin
            phase <= 2'd0;
            bitcnt <= 3'd0;
            // Only idle takes a request, so a byte never cuts into another
            if (go_start) begin
                state <= ST_START;
            end else if (tx_load) begin
                shreg <= xfer_byte;
                dir_rx <= 1'b0;
                state <= ST_DATA;
            end else if (rx_begin) begin
                dir_rx <= 1'b1;
                state <= ST_DATA;
            end else if (go_stop) begin
                state <= ST_STOP;
            end
        end else if (step) begin
            phase <= phase + 2'd1;
            unique case (state)
                ST_START: begin
                    if (phase == 2'd0) sda_oe <= 1'b0;
                    if (phase == 2'd1) scl_oe <= 1'b0;
                    if (phase == 2'd2) sda_oe <= 1'b1;
                    if (phase == 2'd3) begin
                        scl_oe <= 1'b1;
                        bus_busy <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                ST_STOP: begin
                    if (phase == 2'd0) sda_oe <= 1'b1;
                    if (phase == 2'd1) scl_oe <= 1'b0;
                    if (phase == 2'd2) sda_oe <= 1'b0;
                    if (phase == 2'd3) begin
                        bus_busy <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                ST_DATA: begin
                    if (phase == 2'd0) sda_oe <= dir_rx ? 1'b0 : ~shreg[7];
                    if (phase == 2'd1) scl_oe <= 1'b0;
                    if (phase == 2'd2 && dir_rx) shreg <= {shreg[6:0], sda_s};
                    if (phase == 2'd3) begin
                        scl_oe <= 1'b1;
                        bitcnt <= bitcnt + 3'd1;
                        if (!dir_rx) shreg <= {shreg[6:0], 1'b0};
                        if (bitcnt == 3'd7) state <= ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (phase == 2'd0) sda_oe <= dir_rx ? ~ack_bit : 1'b0;
                    if (phase == 2'd1) scl_oe <= 1'b0;
                    // SDA holds as SCL falls, else a slave may see a stop
                    if (phase == 2'd3) begin
                        scl_oe <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Open-drain: only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_txgo_clear: assert property (tx_load && !wr_dat |=> !transmit_go)
        else $error("transmit_go not cleared on load");
    a_tx_cause: assert property (tx_load |=> irq_status[`I2CMD_IRQ_TX] && state == ST_DATA)
        else $error("transmit-empty cause missing");
    a_tx_msb: assert property (q0 && state == ST_DATA && !dir_rx
        |=> sda_oe == !$past(shreg[7]))
        else $error("transmit bit not MSB first");
    a_ack_record: assert property (ack_sample && !wr_dat |=> ack_bit == $past(sda_s))
        else $error("slave reply not recorded");
    a_ack_drive: assert property (q0 && state == ST_ACK && dir_rx
        |=> sda_oe == !$past(ack_bit))
        else $error("reply bit not from ack_bit");
    a_rx_complete: assert property (rx_done
        |=> rx_full_flag && irq_status[`I2CMD_IRQ_RX] && xfer_byte == $past(shreg))
        else $error("received byte not delivered");
    a_rx_shift: assert property (q2 && state == ST_DATA && dir_rx
        |=> shreg[0] == $past(sda_s) && shreg[7:1] == $past(shreg[6:0]))
        else $error("receive shift wrong");
    a_rxgo_clear: assert property (d7_load && !wr_dat |=> !receive_go)
        else $error("receive_go not cleared at D7");
    a_rx_read_clr: assert property (rd_clr |=> !rx_full_flag)
        else $error("read did not clear rx_full_flag");
    a_rx_irq_gate: assert property (!irq_ctrl[1] && !(irq_status[0] && irq_ctrl[0])
        |-> !irq)
        else $error("receive request leaked");
    a_tx_irq_gate: assert property (!irq_ctrl[0] && !(irq_status[1] && irq_ctrl[1])
        |-> !irq)
        else $error("transmit request leaked");
    a_ictl_upper: assert property (setup_rd && hit_ictl |=> prdata[31:2] == 30'h00000000)
        else $error("interrupt control upper bits not zero");
    a_one_byte: assert property (state == ST_DATA && $past(state) != ST_DATA
        |-> $past(state) == ST_IDLE && $past(tx_load || rx_begin))
        else $error("byte started during transfer");

    c_tx_byte: cover property (ack_sample && sda_s);
    c_rx_byte: cover property (rx_done && receive_go);
    c_irq: cover property ($rose(irq));
    c_overwrite: cover property (rx_done && rx_full_flag);
endmodule

// *** test/i2cmd_slave.sv ***
// Purpose: I2C slave model for the master's far side
// Assumes: Open-drain lines with pull-ups; line levels come in
// Notes:   Bytes only, no address decode
`timescale 1ns/1ns
module i2cmd_slave (
    input wire logic scl,
    input wire logic sda,
    input wire logic send_mode,
    input wire logic [7:0] send_byte,
    input wire logic nack,
    input wire logic [31:0] stretch_ns,
    output logic scl_oe,
    output logic sda_oe,
    output logic [7:0] got,
    output logic got_ack,
    output int n_got
);
    // ==========================================================
    // Framing
    logic active = 1'b0;
    logic [3:0] cnt = 4'hf;
    initial begin
        scl_oe = 1'b0;
        got = 8'h00;
        got_ack = 1'b0;
        n_got = 0;
    end
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            active = 1'b1;
            cnt = 4'hf;
        end
    end
    always @(posedge sda) begin
        if (scl === 1'b1) active = 1'b0;
    end
    // ==========================================================
    // Bits; a stretch before each byte makes the master wait
    always @(negedge scl) begin
        if (active) begin
            cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
            if (cnt == 4'h0 && stretch_ns > 0) begin
                scl_oe = 1'b1;
                #(stretch_ns);
                scl_oe = 1'b0;
            end
        end
    end
    always @(posedge scl) begin
        if (active && cnt < 4'h8) got = {got[6:0], sda};
        if (active && cnt == 4'h8) begin
            got_ack = sda;
            n_got = n_got + 1;
        end
    end
    // Drive changes only at falling clock edges, so no false start or stop
    assign sda_oe = active && cnt != 4'hf && (cnt < 4'h8 ?
        send_mode && !send_byte[3'd7 - cnt[2:0]] :
        !send_mode && !nack);
endmodule

// *** test/tb.sv ***
// Purpose: Self-checking bench for the I2C master data path
// Assumes: Slave model on the far side, pull-ups on both lines
// Notes:   Reads and slave bytes are checked from queues
`timescale 1ns/1ns
`include "i2cmd_params.svh"
module tb;
    // ==========================================================
    // Map and signals
    localparam logic [31:0] A_EN = {14'h0000, `I2CMD_IDX_EN, 2'b00};
    localparam logic [31:0] A_CTL = {14'h0000, `I2CMD_IDX_CTL, 2'b00};
    localparam logic [31:0] A_DAT = {14'h0000, `I2CMD_IDX_DAT, 2'b00};
    localparam logic [31:0] A_ICTL = {14'h0000, `I2CMD_IDX_ICTL, 2'b00};
    localparam logic [31:0] A_ISTS = {14'h0000, `I2CMD_IDX_ISTS, 2'b00};
    localparam logic [31:0] TXGO = 32'h1 << `I2CMD_DAT_TXGO;
    localparam logic [31:0] RXGO = 32'h1 << `I2CMD_DAT_RXGO;
    localparam logic [31:0] ACK = 32'h1 << `I2CMD_DAT_ACK;
    localparam logic [31:0] FULL = 32'h1 << `I2CMD_DAT_RXFULL;
    typedef struct {
        logic [31:0] ex;
        logic [31:0] m;
        string nm;
    } i2cmd_note_t;
    i2cmd_note_t rq[$];
    i2cmd_note_t n1;
    logic [8:0] sq[$];
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
    logic pready, pslverr, irq, scl_oe, sda_oe, s_scl_oe, s_sda_oe, s_ack, err, scl_o, sda_o;
    logic send_mode = 1'b0, nack = 1'b0;
    logic [7:0] send_byte = 8'h00, s_got, by[5];
    int stretch = 0, n_got, n_mismatch = 0, checks_done = 0;
    // A pin that drives a high would defeat the pull-up and show here
    wire scl_l = ~s_scl_oe & (scl_oe ? scl_o : 1'b1);
    wire sda_l = ~s_sda_oe & (sda_oe ? sda_o : 1'b1);
    always #10 pclk = ~pclk;
    i2cmd_top i2cmd_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .scl_i(scl_l),
        .sda_i(sda_l), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe));
    i2cmd_slave i2cmd_slave_inst (.scl(scl_l), .sda(sda_l), .send_mode(send_mode),
        .send_byte(send_byte), .nack(nack), .stretch_ns(stretch), .scl_oe(s_scl_oe),
        .sda_oe(s_sda_oe), .got(s_got), .got_ack(s_ack), .n_got(n_got));
    // ==========================================================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        checks_done++;
        if (seen !== ex) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] dt);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= dt;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] ad, input logic [31:0] dt);
        apb(1'b1, ad, dt);
        @(posedge pclk);
    endtask
    task automatic rd(input logic [31:0] ad, input logic [31:0] ex, input logic [31:0] m,
        input string nm);
        rq.push_back('{ex, m, nm});
        apb(1'b0, ad, 32'h0);
    endtask
    task automatic poll(input logic [31:0] ad, input int bn, input logic v);
        int i;
        for (i = 0; i < 4000; i++) begin
            rd(ad, 32'h0, 32'h0, "poll");
            if (q[bn] === v) break;
        end
        if (i == 4000) n_mismatch++;
    endtask
    task automatic wait_irq();
        for (int i = 0; i < 6000 && irq !== 1'b1; i++) @(posedge pclk);
        chk("irq_rx", {31'h0, irq}, 32'h1);
    endtask
    task automatic wait_got(input int n);
        for (int i = 0; i < 9000 && n_got < n; i++) @(posedge pclk);
        if (n_got < n) n_mismatch++;
    endtask
    task automatic stop_test();
        $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Watchers
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0) begin
            n1 = rq.pop_front();
            if (n1.m !== 32'h0) chk(n1.nm, prdata & n1.m, n1.ex & n1.m);
        end
    end
    always @(n_got) begin
        if (n_got > 0) chk("slave", {23'h0, s_got, s_ack}, {23'h0, sq.pop_front()});
    end
    initial begin
        #1800000;
        n_mismatch++;
        stop_test();
    end
    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(62287));
        foreach (by[i]) by[i] = 8'($urandom);
        // Long enough to outlast the master's release, so the stall path runs
        stretch = 11000 + int'($urandom % 8000);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_DAT, 32'h0, 32'hffffffff, "dat_reset");
        rd(A_ICTL, 32'h0, 32'hffffffff, "ictl_reset");
        wr(A_ICTL, 32'hffffffff);
        rd(A_ICTL, 32'h3, 32'hffffffff, "ictl_bits");
        wr(A_ICTL, 32'h0);
        rd(A_ISTS + 32'h40, 32'h0, 32'hffffffff, "unmapped");
        chk("slverr", {31'h0, err}, 32'h1);
        // Two bytes out, the second queued behind the first
        wr(A_EN, 32'h1);
        wr(A_CTL, 32'h1);
        sq.push_back({by[0], 1'b0});
        sq.push_back({by[1], 1'b1});
        wr(A_DAT, TXGO | by[0]);
        poll(A_DAT, `I2CMD_DAT_TXGO, 1'b0);
        rd(A_ISTS, 32'h1, 32'h1, "tx_empty");
        chk("irq_masked", {31'h0, irq}, 32'h0);
        wr(A_ICTL, 32'h1);
        chk("irq_tx", {31'h0, irq}, 32'h1);
        wr(A_DAT, TXGO | by[1]);
        rd(A_DAT, TXGO | by[1], 32'h2ff, "tx_queued");
        wait_got(1);
        @(negedge scl_l);
        nack = 1'b1;
        poll(A_DAT, `I2CMD_DAT_TXGO, 1'b0);
        rd(A_DAT, 32'h0, ACK, "ack_seen");
        poll(A_CTL, `I2CMD_CTL_TXBUSY, 1'b0);
        rd(A_DAT, ACK, ACK, "nack_seen");
        wr(A_ISTS, 32'h3);
        wr(A_ICTL, 32'h2);
        chk("irq_clear", {31'h0, irq}, 32'h0);
        // Receive one byte, then two with the second queued
        send_mode = 1'b1;
        send_byte = by[2];
        sq.push_back({by[2], 1'b0});
        wr(A_DAT, RXGO);
        wait_irq();
        rd(A_DAT, FULL | by[2], 32'hfff, "rx_byte");
        rd(A_DAT, 32'h0, FULL, "rx_read_clr");
        wr(A_ISTS, 32'h2);
        send_byte = by[3];
        sq.push_back({by[3], 1'b1});
        sq.push_back({by[4], 1'b1});
        wr(A_DAT, RXGO);
        poll(A_DAT, `I2CMD_DAT_RXGO, 1'b0);
        wr(A_DAT, RXGO | ACK);
        rd(A_DAT, RXGO | ACK, RXGO | ACK, "rx_queued");
        wait_got(4);
        send_byte = by[4];
        wr(A_ISTS, 32'h2);
        wait_irq();
        rd(A_DAT, FULL | ACK | by[4], 32'hfff, "rx_overwrite");
        // Refused last byte: the slave lets go of the data line
        send_mode = 1'b0;
        wr(A_CTL, 32'h2);
        poll(A_CTL, `I2CMD_CTL_STOP, 1'b0);
        chk("bus_free", {30'h0, scl_l, sda_l}, 32'h3);
        chk("bytes", n_got, 32'd5);
        stop_test();
    end
endmodule
